// ===== rtid_defines.svh
// register offsets, field positions, reset values and frame constants
`ifndef RTID_DEFINES_SVH
`define RTID_DEFINES_SVH

// register offsets on the serial bus
`define RTID_ADDR_SWITCH 5'h00
`define RTID_ADDR_GROUP 5'h1b
`define RTID_ADDR_PWRTRIG 5'h1c
`define RTID_ADDR_PART 5'h1d
`define RTID_ADDR_MAKER 5'h1e
`define RTID_ADDR_IDENT 5'h1f

// power and trigger control field positions
`define RTID_PM_HI 7
`define RTID_PM_LO 6
`define RTID_MASK_HI 5
`define RTID_MASK_LO 3
`define RTID_TRIG_HI 2
`define RTID_TRIG_LO 0
`define RTID_SOFT_RST_BIT 7

// power state codes
`define RTID_PM_ACTIVE 2'h0
`define RTID_PM_STARTUP 2'h1
`define RTID_PM_LOWPWR 2'h2
`define RTID_PM_RESERVED 2'h3

// reset values
`define RTID_GROUP_ID_RST 4'h0
`define RTID_SLAVE_ID_RST 4'ha
`define RTID_PM_RST 2'h0
`define RTID_MASK_RST 3'h0
`define RTID_SWITCH_RST 7'h00

// identification codes, values arbitrary
`define RTID_PART_CODE 8'h3c
`define RTID_MAKER_CODE 8'h96
`define RTID_MAKER_BITS 2'h2

// frame layout
`define RTID_CMD_LAST 4'hc
`define RTID_DATA_LAST 4'h8
`define RTID_CMD_WRITE 2'h2
`define RTID_CMD_READ 2'h3
`define RTID_BROADCAST_ID 4'h0

`endif

// ===== rtid_pkg.sv
// types shared by the trigger and identifier register bank
`default_nettype none
package rtid_pkg;
    // serial frame parser states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARMED,
        ST_CMD,
        ST_WDATA,
        ST_RPARK,
        ST_RDATA,
        ST_REND
    } rtid_state_t;
endpackage : rtid_pkg
`default_nettype wire

// ===== rtid_sync.sv
// two-flop synchroniser for the serial clock and data pins
`timescale 1ns/1ps
`default_nettype none
module rtid_sync (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic [1:0] async_in,
    output logic [1:0] sync_out
);
    logic [1:0] stage1;
    logic [1:0] stage2;

    // ------------------------------------------------------------
    // metastability stages, one pair per bit
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_bit
            always_ff @(posedge core_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    stage1[g] <= 1'b0;
                    stage2[g] <= 1'b0;
                end else begin
                    stage1[g] <= async_in[g];
                    stage2[g] <= stage1[g];
                end
            end
        end
    endgenerate

    assign sync_out = stage2;
endmodule : rtid_sync
`default_nettype wire

// ===== rtid_trig.sv
// shadow and destination store for the triggerable switch control
`timescale 1ns/1ps
`default_nettype none
`include "rtid_defines.svh"
module rtid_trig (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic wr_in,
    input wire logic [6:0] wr_data_in,
    input wire logic [2:0] masks_in,
    input wire logic [2:0] strobes_in,
    input wire logic defaults_in,
    output logic [6:0] switch_out,
    output logic [6:0] shadow_out
);
    logic fire;
    logic all_masked;
    logic [6:0] next_switch;
    logic [6:0] next_shadow;

    // ------------------------------------------------------------
    // shadow write, bypass and trigger transfer
    // ------------------------------------------------------------
    always_comb begin
        all_masked = &masks_in;
        fire = |(strobes_in & ~masks_in);
        next_switch = switch_out;
        next_shadow = shadow_out;
        if (defaults_in) begin
            next_switch = `RTID_SWITCH_RST;
            next_shadow = `RTID_SWITCH_RST;
        end else if (wr_in) begin
            next_shadow = wr_data_in;
            if (all_masked) begin
                next_switch = wr_data_in;
            end
        end else if (fire) begin
            next_switch = shadow_out;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            switch_out <= `RTID_SWITCH_RST;
            shadow_out <= `RTID_SWITCH_RST;
        end else begin
            switch_out <= next_switch;
            shadow_out <= next_shadow;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_bypass;
        (wr_in && !defaults_in && (&masks_in)) |=> switch_out == $past(wr_data_in);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass write missed");

    property p_fire_copies;
        (!wr_in && !defaults_in && |(strobes_in & ~masks_in))
            |=> switch_out == $past(shadow_out);
    endproperty
    a_fire_copies: assert property (p_fire_copies) else $error("trigger copy wrong");

    property p_masked_hold;
        (!wr_in && !defaults_in && !(|(strobes_in & ~masks_in))) |=> $stable(switch_out);
    endproperty
    a_masked_hold: assert property (p_masked_hold) else $error("masked trigger acted");

    property p_multi_fire;
        (!wr_in && !defaults_in && $countones(strobes_in & ~masks_in) > 1)
            |=> switch_out == $past(shadow_out) && shadow_out == $past(shadow_out);
    endproperty
    a_multi_fire: assert property (p_multi_fire) else $error("multi trigger differs");
endmodule : rtid_trig
`default_nettype wire

// ===== rtid_regs.sv
// serial bus slave with trigger, power state and identifier registers
//
// Overview of operation
// - power state bits 7:6: active, low, reserved
// - writing code 01 resets switch control and shadow, enters active
// - three trigger masks bits 5:3, reset zero
// - all masks set: writes bypass shadow stage
// - trigger 2 strobe loads pending shadow data
// - triggers 1 and 0 alias common transfer
// - unmasked trigger transfers all shadows; masked ignored
// - several triggers equal one single transfer
// - part code read-only, writes accepted, unchanged
// - slave identifier low four bits, reset 1010
// - soft reset keeps identifiers and power register
// - masks set: commit at end of write sequence
`timescale 1ns/1ps
`default_nettype none
`include "rtid_defines.svh"
module rtid_regs #(
    parameter logic [7:0] PART_CODE = `RTID_PART_CODE, // arbitrary value
    parameter logic [7:0] MAKER_CODE = `RTID_MAKER_CODE, // arbitrary value
    parameter logic [1:0] MAKER_BITS = `RTID_MAKER_BITS // arbitrary value
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic sclk_in,
    input wire logic sdata_in,
    output logic sdata_out,
    output logic sdata_oe_n_out,
    output logic [1:0] power_state_out,
    output logic [6:0] switch_ctrl_out
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [1:0] pins_sync;
    logic sclk_s, sdata_s;
    logic sclk_q, sdata_q;
    logic sclk_rise, sclk_fall;
    rtid_pkg::rtid_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [11:0] cmd, next_cmd;
    logic [7:0] shift, next_shift;
    logic hit_wr, next_hit_wr;
    logic wr_go, next_wr_go;
    logic [4:0] wr_addr, next_wr_addr;
    logic [7:0] wr_data, next_wr_data;
    logic [8:0] rd_shift, next_rd_shift;
    logic next_sdata, next_oe_n;
    logic [3:0] group_slave_identifier, next_group_slave_identifier;
    logic [3:0] unique_slave_identifier, next_unique_slave_identifier;
    logic [2:0] masks, next_masks;
    logic [1:0] next_pm;
    logic pm_wr, soft_rst, startup, sw_wr;
    logic [2:0] strobes;
    logic [6:0] shadow;

    // decide whether a command frame addresses this slave
    function automatic logic addr_hit(input logic [3:0] sa, input logic [3:0] uid,
                                      input logic [3:0] gid, input logic is_wr);
        addr_hit = (sa == uid) || (is_wr && ((sa == gid) || (sa == `RTID_BROADCAST_ID)));
    endfunction : addr_hit

    // read value of each register, unmapped reads as zero
    function automatic logic [7:0] rd_value(input logic [4:0] a);
        unique case (a)
            `RTID_ADDR_SWITCH: rd_value = {1'b0, switch_ctrl_out};
            `RTID_ADDR_GROUP: rd_value = {4'h0, group_slave_identifier};
            `RTID_ADDR_PWRTRIG: rd_value = {power_state_out, masks, 3'h0};
            `RTID_ADDR_PART: rd_value = PART_CODE;
            `RTID_ADDR_MAKER: rd_value = MAKER_CODE;
            `RTID_ADDR_IDENT: rd_value = {2'h0, MAKER_BITS, unique_slave_identifier};
            default: rd_value = 8'h00;
        endcase
    endfunction : rd_value

    // ------------------------------------------------------------
    // pin synchronisation and edge detection
    // ------------------------------------------------------------
    rtid_sync u_sync (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .async_in({sclk_in, sdata_in}),
        .sync_out(pins_sync)
    );

    assign sclk_s = pins_sync[1];
    assign sdata_s = pins_sync[0];
    assign sclk_rise = sclk_s && !sclk_q;
    assign sclk_fall = !sclk_s && sclk_q;

    // ------------------------------------------------------------
    // frame parser next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_cmd = cmd;
        next_shift = shift;
        next_hit_wr = hit_wr;
        next_wr_go = 1'b0;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_rd_shift = rd_shift;
        next_sdata = sdata_out;
        next_oe_n = sdata_oe_n_out;
        unique case (state)
            rtid_pkg::ST_IDLE: begin
                if (!sclk_s && sdata_s && !sdata_q) begin
                    next_state = rtid_pkg::ST_ARMED;
                end
            end
            rtid_pkg::ST_ARMED: begin
                if (sclk_s) begin
                    next_state = rtid_pkg::ST_IDLE;
                end else if (!sdata_s && sdata_q) begin
                    next_state = rtid_pkg::ST_CMD;
                    next_cnt = 4'h0;
                end
            end
            rtid_pkg::ST_CMD: begin
                if (sclk_fall) begin
                    next_cmd = {cmd[10:0], sdata_s};
                    next_cnt = cnt + 4'h1;
                    if (cnt == `RTID_CMD_LAST) begin
                        next_cnt = 4'h0;
                        next_state = rtid_pkg::ST_IDLE;
                        next_hit_wr = (^{cmd[11:0], sdata_s})
                            && addr_hit(cmd[11:8], unique_slave_identifier,
                                        group_slave_identifier,
                                        cmd[7] || cmd[6:5] == `RTID_CMD_WRITE);
                        next_wr_addr = cmd[4:0];
                        if (cmd[7]) begin
                            // register 0 short write commits at frame end
                            next_wr_go = next_hit_wr;
                            next_wr_addr = `RTID_ADDR_SWITCH;
                            next_wr_data = {1'b0, cmd[6:0]};
                        end else if (cmd[6:5] == `RTID_CMD_WRITE) begin
                            next_state = rtid_pkg::ST_WDATA;
                        end else if (cmd[6:5] == `RTID_CMD_READ && next_hit_wr
                                     && cmd[11:8] == unique_slave_identifier) begin
                            next_state = rtid_pkg::ST_RPARK;
                        end
                    end
                end
            end
            rtid_pkg::ST_WDATA: begin
                if (sclk_fall) begin
                    next_shift = {shift[6:0], sdata_s};
                    next_cnt = cnt + 4'h1;
                    if (cnt == `RTID_DATA_LAST) begin
                        // data frame with good odd parity commits at sequence end
                        next_wr_go = hit_wr && (^{shift[7:0], sdata_s});
                        next_wr_data = shift[7:0];
                        next_state = rtid_pkg::ST_IDLE;
                    end
                end
            end
            rtid_pkg::ST_RPARK: begin
                if (sclk_fall) begin
                    next_rd_shift = {rd_value(wr_addr), ~^rd_value(wr_addr)};
                    next_state = rtid_pkg::ST_RDATA;
                end
            end
            rtid_pkg::ST_RDATA: begin
                if (sclk_rise) begin
                    next_sdata = rd_shift[8];
                    next_oe_n = 1'b0;
                    next_rd_shift = {rd_shift[7:0], 1'b0};
                end
                if (sclk_fall) begin
                    next_cnt = cnt + 4'h1;
                    if (cnt == `RTID_DATA_LAST) begin
                        next_state = rtid_pkg::ST_REND;
                    end
                end
            end
            rtid_pkg::ST_REND: begin
                // bus park: drive low for one half cycle, then release
                if (sclk_rise) begin
                    next_sdata = 1'b0;
                end
                if (sclk_fall) begin
                    next_oe_n = 1'b1;
                    next_state = rtid_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = rtid_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sclk_q <= 1'b0;
            sdata_q <= 1'b0;
            state <= rtid_pkg::ST_IDLE;
            cnt <= 4'h0;
            cmd <= 12'h000;
            shift <= 8'h00;
            hit_wr <= 1'b0;
            wr_go <= 1'b0;
            wr_addr <= 5'h00;
            wr_data <= 8'h00;
            rd_shift <= 9'h000;
            sdata_out <= 1'b0;
            sdata_oe_n_out <= 1'b1;
        end else begin
            sclk_q <= sclk_s;
            sdata_q <= sdata_s;
            state <= next_state;
            cnt <= next_cnt;
            cmd <= next_cmd;
            shift <= next_shift;
            hit_wr <= next_hit_wr;
            wr_go <= next_wr_go;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            rd_shift <= next_rd_shift;
            sdata_out <= next_sdata;
            sdata_oe_n_out <= next_oe_n;
        end
    end

    // ------------------------------------------------------------
    // register write decode
    // ------------------------------------------------------------
    always_comb begin
        pm_wr = wr_go && (wr_addr == `RTID_ADDR_PWRTRIG);
        soft_rst = wr_go && (wr_addr == `RTID_ADDR_SWITCH) && wr_data[`RTID_SOFT_RST_BIT];
        startup = pm_wr && (wr_data[`RTID_PM_HI:`RTID_PM_LO] == `RTID_PM_STARTUP);
        sw_wr = wr_go && (wr_addr == `RTID_ADDR_SWITCH) && !wr_data[`RTID_SOFT_RST_BIT];
        strobes = pm_wr ? wr_data[`RTID_TRIG_HI:`RTID_TRIG_LO] : 3'h0;
        next_group_slave_identifier = group_slave_identifier;
        next_unique_slave_identifier = unique_slave_identifier;
        next_masks = masks;
        next_pm = power_state_out;
        if (wr_go && wr_addr == `RTID_ADDR_GROUP) begin
            next_group_slave_identifier = wr_data[3:0];
        end
        if (wr_go && wr_addr == `RTID_ADDR_IDENT) begin
            next_unique_slave_identifier = wr_data[3:0];
        end
        if (pm_wr) begin
            next_masks = wr_data[`RTID_MASK_HI:`RTID_MASK_LO];
            unique case (wr_data[`RTID_PM_HI:`RTID_PM_LO])
                `RTID_PM_ACTIVE: next_pm = `RTID_PM_ACTIVE;
                `RTID_PM_STARTUP: next_pm = `RTID_PM_ACTIVE;
                `RTID_PM_LOWPWR: next_pm = `RTID_PM_LOWPWR;
                `RTID_PM_RESERVED: next_pm = power_state_out;
            endcase
        end
    end

    // soft reset leaves identifiers and power register untouched
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            group_slave_identifier <= `RTID_GROUP_ID_RST;
            unique_slave_identifier <= `RTID_SLAVE_ID_RST;
            masks <= `RTID_MASK_RST;
            power_state_out <= `RTID_PM_RST;
        end else begin
            group_slave_identifier <= next_group_slave_identifier;
            unique_slave_identifier <= next_unique_slave_identifier;
            masks <= next_masks;
            power_state_out <= next_pm;
        end
    end

    // ------------------------------------------------------------
    // triggerable switch control store
    // ------------------------------------------------------------
    rtid_trig u_trig (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .wr_in(sw_wr),
        .wr_data_in(wr_data[6:0]),
        .masks_in(pm_wr ? wr_data[`RTID_MASK_HI:`RTID_MASK_LO] : masks),
        .strobes_in(strobes),
        .defaults_in(soft_rst || startup),
        .switch_out(switch_ctrl_out),
        .shadow_out(shadow)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_low_power;
        (pm_wr && wr_data[7:6] == 2'h2) |=> power_state_out == 2'h2;
    endproperty
    a_low_power: assert property (p_low_power) else $error("low power not entered");
    property p_startup;
        startup |=> (power_state_out == 2'h0 && switch_ctrl_out == 7'h00 && shadow == 7'h00);
    endproperty
    a_startup: assert property (p_startup) else $error("startup defaults missing");
    property p_masks;
        pm_wr |=> masks == $past(wr_data[5:3]);
    endproperty
    a_masks: assert property (p_masks) else $error("masks not stored");
    property p_part_read;
        (state == rtid_pkg::ST_RPARK && sclk_fall && wr_addr == 5'h1d)
            |=> rd_shift[8:1] == PART_CODE;
    endproperty
    a_part_read: assert property (p_part_read) else $error("part code read wrong");
    property p_slave_id;
        (wr_go && wr_addr == 5'h1f) |=> unique_slave_identifier == $past(wr_data[3:0]);
    endproperty
    a_slave_id: assert property (p_slave_id) else $error("identifier not written");
    property p_group_id;
        (wr_go && wr_addr == 5'h1b) |=> group_slave_identifier == $past(wr_data[3:0]);
    endproperty
    a_group_id: assert property (p_group_id) else $error("group identifier not written");
    property p_soft_keep;
        soft_rst |=> $stable(unique_slave_identifier) && $stable(group_slave_identifier)
            && $stable(masks) && $stable(power_state_out);
    endproperty
    a_soft_keep: assert property (p_soft_keep) else $error("soft reset lost state");
    sequence s_direct_write;
        sw_wr && (&masks) && !pm_wr;
    endsequence
    sequence s_direct_commit;
        ##1 switch_ctrl_out == $past(wr_data[6:0]) ##1 $stable(switch_ctrl_out) || wr_go;
    endsequence
    property p_direct;
        s_direct_write |-> s_direct_commit;
    endproperty
    a_direct: assert property (p_direct) else $error("direct commit missed");
endmodule : rtid_regs
`default_nettype wire

// ===== rtid_master.sv
// bus master model: drives serial clock and data, reads back slave data
`timescale 1ns/1ps
`default_nettype none
module rtid_master (
    input wire logic clk_in,
    input wire logic sdata_in,
    output logic sclk_out,
    output logic sdata_out,
    output logic drv_n_out
);
    // --------------------------------------------------------------
    // idle: clock low and still, data driven low
    // --------------------------------------------------------------
    initial begin
        sclk_out = 1'b0;
        sdata_out = 1'b0;
        drv_n_out = 1'b0;
    end
    // one bit: rise with data, fall, sample late in low phase
    task automatic bit_cyc(input logic b, input logic rel, output logic s);
        @(posedge clk_in);
        sclk_out <= 1'b1;
        drv_n_out <= rel;
        if (!rel) begin
            sdata_out <= b;
        end
        repeat (4) @(posedge clk_in);
        sclk_out <= 1'b0;
        repeat (3) @(posedge clk_in);
        #1 s = sdata_in;
    endtask : bit_cyc
    // msb first
    task automatic send(input logic [12:0] v, input int n);
        logic s;
        for (int i = n - 1; i >= 0; i--) begin
            bit_cyc(v[i], 1'b0, s);
        end
    endtask : send
    // start: data pulse while clock low
    task automatic ssc(input logic [3:0] sa, input logic [7:0] c);
        @(posedge clk_in);
        drv_n_out <= 1'b0;
        sdata_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        sdata_out <= 1'b0;
        repeat (3) @(posedge clk_in);
        send({sa, c, ~^{sa, c}}, 13);
    endtask : ssc
    // register write, then bus park
    task automatic wr(input logic [3:0] sa, input logic [4:0] a, input logic [7:0] d);
        logic s;
        ssc(sa, {3'b010, a});
        send({4'h0, d, ~^d}, 9);
        bit_cyc(1'b0, 1'b0, s);
        repeat (8) @(posedge clk_in);
    endtask : wr
    // short write of register 0
    task automatic w0(input logic [3:0] sa, input logic [6:0] d);
        logic s;
        ssc(sa, {1'b1, d});
        bit_cyc(1'b0, 1'b0, s);
        repeat (8) @(posedge clk_in);
    endtask : w0
    // register read: park, 8 data bits and parity, final park
    task automatic rd(input logic [3:0] sa, input logic [4:0] a, output logic [8:0] v);
        logic s;
        ssc(sa, {3'b011, a});
        bit_cyc(1'b0, 1'b1, s);
        for (int i = 0; i < 9; i++) begin
            bit_cyc(1'b0, 1'b1, s);
            v = {v[7:0], s};
        end
        bit_cyc(1'b0, 1'b1, s);
        @(posedge clk_in);
        drv_n_out <= 1'b0;
        sdata_out <= 1'b0;
        repeat (8) @(posedge clk_in);
    endtask : rd
endmodule : rtid_master
`default_nettype wire

// ===== rtid_regs_test.sv
// self-checking bench for the trigger and identifier register bank
`timescale 1ns/1ps
`default_nettype none
`include "rtid_defines.svh"
module rtid_regs_test;
    logic core_clk_in, rst_n_in, sclk, m_dat, m_drv_n, sdata_w, s_dat, s_oe_n;
    logic [1:0] pwr;
    logic [6:0] sw;
    logic [8:0] rd;
    int err_count, checked;
    // --------------------------------------------------------------
    // wire: slave, else master, else inverse of last level
    // --------------------------------------------------------------
    assign sdata_w = !s_oe_n ? s_dat : (!m_drv_n ? m_dat : ~m_dat);
    rtid_regs DUT (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk),
        .sdata_in(sdata_w), .sdata_out(s_dat), .sdata_oe_n_out(s_oe_n),
        .power_state_out(pwr), .switch_ctrl_out(sw));
    rtid_master u_master (.clk_in(core_clk_in), .sdata_in(sdata_w), .sclk_out(sclk),
        .sdata_out(m_dat), .drv_n_out(m_drv_n));
    // compare and count
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    // read and compare data with odd parity
    task automatic rchk(input logic [3:0] sa, input logic [4:0] a, input logic [7:0] e);
        u_master.rd(sa, a, rd);
        check(rd, {e, ~^e});
    endtask : rchk
    // outputs and registers after reset
    task automatic t_reset;
        check({s_oe_n, pwr, sw[5:0]}, 9'h100);
        rchk(4'ha, 5'h1b, 8'h00);
        rchk(4'ha, 5'h1c, 8'h00);
        rchk(4'ha, 5'h1d, `RTID_PART_CODE);
        rchk(4'ha, 5'h1e, `RTID_MAKER_CODE);
        rchk(4'ha, 5'h1f, {2'b00, `RTID_MAKER_BITS, 4'ha});
    endtask : t_reset
    // identifier writes, read-only codes
    task automatic t_ids;
        u_master.wr(4'ha, 5'h1b, 8'hf7);
        rchk(4'ha, 5'h1b, 8'h07);
        u_master.wr(4'ha, 5'h1d, 8'h00);
        rchk(4'ha, 5'h1d, `RTID_PART_CODE);
        u_master.wr(4'ha, 5'h1e, 8'h00);
        rchk(4'ha, 5'h1e, `RTID_MAKER_CODE);
        u_master.wr(4'ha, 5'h1f, 8'hf5);
        rchk(4'h5, 5'h1f, {2'b00, `RTID_MAKER_BITS, 4'h5});
    endtask : t_ids
    // shadow transfer by triggers, group address used for writes
    task automatic t_trig;
        u_master.w0(4'h7, 7'h15);
        check({2'b0, sw}, 9'h000);
        u_master.wr(4'h7, 5'h1c, 8'h0c);
        check({2'b0, sw}, 9'h015);
        u_master.w0(4'h7, 7'h33);
        u_master.wr(4'h5, 5'h1c, 8'h09);
        check({2'b0, sw}, 9'h015);
        u_master.wr(4'h5, 5'h1c, 8'h0a);
        check({2'b0, sw}, 9'h033);
        rchk(4'h5, 5'h1c, 8'h08);
        u_master.w0(4'h5, 7'h5a);
        u_master.wr(4'h5, 5'h1c, 8'h01);
        check({2'b0, sw}, 9'h05a);
        u_master.w0(4'h0, 7'h4c);
        u_master.wr(4'h5, 5'h1c, 8'h07);
        check({2'b0, sw}, 9'h04c);
        u_master.wr(4'h5, 5'h1c, 8'h38);
        u_master.w0(4'h5, 7'h61);
        check({2'b0, sw}, 9'h061);
        rchk(4'h5, 5'h00, 8'h61);
    endtask : t_trig
    // soft reset keeps identifiers and power register
    task automatic t_soft;
        u_master.wr(4'h5, 5'h1c, 8'hb8);
        check({7'h0, pwr}, 9'h002);
        u_master.wr(4'h5, 5'h00, 8'h80);
        check({pwr, sw}, 9'h100);
        rchk(4'h5, 5'h1c, 8'hb8);
        rchk(4'h5, 5'h1b, 8'h07);
    endtask : t_soft
    // reserved power code kept out, startup restores switch and power defaults
    task automatic t_power;
        u_master.wr(4'h5, 5'h1c, 8'hf8);
        check({7'h0, pwr}, 9'h002);
        u_master.w0(4'h5, 7'h2a);
        u_master.wr(4'h5, 5'h1c, 8'h78);
        check({pwr, sw}, 9'h000);
        rchk(4'h5, 5'h1c, 8'h38);
    endtask : t_power
    // verdict and end of run
    task automatic stop_test;
        if (err_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    // --------------------------------------------------------------
    // clock, reset, sequence and watchdog
    // --------------------------------------------------------------
    initial begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end
    initial begin
        err_count = 0;
        checked = 0;
        rst_n_in = 1'b0;
        repeat (4) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        t_reset();
        t_ids();
        t_trig();
        t_soft();
        t_power();
        stop_test();
    end
    initial begin
        repeat (60000) @(posedge core_clk_in);
        err_count++;
        stop_test();
    end
endmodule : rtid_regs_test
`default_nettype wire
